// >>> scm_status_control.sv
/*
 * Status and control module: sticky or transparent status with masked
 * interrupt, per-bit direct/sync/pulse control outputs, counter mode,
 * four-bit double synchronizer and datapath parallel connection.
 * Assumes the bus clock is clk_i, sc_tick_i marks status-and-control clock
 * edges, bus inputs are synchronous, and wakeup is a reset_n_i pulse.
 */
// Functional notes
// - Eight-bit read-only status from routed inputs
// - Status resets to zero after wakeup
// - Mode zero reads live input level
// - Mode one captures high samples stickily
// - Read clears only bits that were set
// - Clear on bus read, independent of tick
// - Read data latched stable during access
// - Interrupt is masked OR of low seven
// - Interrupt shown on status top bit
// - Eight-bit read-write control drives routing
// - Control resets to zero after wakeup
// - Mode code from high and low bits
// - Direct mode drives output on write
// - Sync mode output resampled on tick
// - Counter mode replaces control register
// - Sync mode: four-bit two-stage synchronizer
// - Parallel datapath input and output connection
// - Pulse mode: one tick high, self-clear
// - Interrupt enable gates interrupt output
// - Counter reloads period at zero
// - Mask register doubles as period
`timescale 1ns/1ns
module scm_status_control (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  sc_tick_i,
    // Register bus
    input  wire scm_pkg::scm_bus_req_t bus_req_i,
    output logic [7:0]                 bus_rdata_o,
    // Routing
    input  wire logic [7:0]            status_in_i,
    input  wire logic [3:0]            module_routed_inputs_i,
    input  wire logic [1:0]            counter_enable_load_inputs_i,
    output logic [7:0]                 module_routed_outputs_o,
    output logic [3:0]                 module_bidir_outputs_o,
    output logic [3:0]                 module_bidir_oe_o,
    // Datapath
    input  wire logic [7:0]            datapath_parallel_out_i,
    output logic [7:0]                 datapath_parallel_in_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] event_status;
    logic [7:0] routed_control;
    logic [7:0] control_mode_high;
    logic [7:0] control_mode_low;
    logic [7:0] interrupt_mask;
    logic [7:0] aux_control;
    logic [7:0] module_config;
    logic [7:0] control_sync;
    logic [7:0] pulse_active;
    logic [3:0] sync_stage1;
    logic [3:0] sync_stage2;
    logic       read_active;
    logic [6:0] count;
    logic       terminal;

    logic       status_capture_sel;
    logic       synchronizer_mode_select;
    logic       interrupt_mode_select;
    logic [1:0] module_output_select;
    logic       counter_mode;
    logic       rd_status;
    logic       wr_control;
    logic       irq;
    logic [7:0] status_view;
    logic [7:0] next_rdata;
    logic [7:0] control_out;

    assign status_capture_sel       = module_config[scm_pkg::CFG_CAPTURE];
    assign synchronizer_mode_select = module_config[scm_pkg::CFG_SYNCHRONIZER_MODE_SELECT];
    assign interrupt_mode_select    = module_config[scm_pkg::CFG_INTERRUPT_MODE_SELECT];
    assign module_output_select     = module_config[scm_pkg::CFG_OUT_SEL_HI:scm_pkg::CFG_OUT_SEL_LO];
    assign counter_mode             = (module_output_select == scm_pkg::OUT_COUNTER);
    assign rd_status  = bus_req_i.read && (bus_req_i.addr == scm_pkg::ADDR_STATUS) && !read_active;
    assign wr_control = bus_req_i.write && (bus_req_i.addr == scm_pkg::ADDR_CONTROL) && !counter_mode;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            control_mode_high <= scm_pkg::RESET_MODE;
            control_mode_low  <= scm_pkg::RESET_MODE;
            interrupt_mask    <= scm_pkg::RESET_MASK;
            aux_control       <= scm_pkg::RESET_AUX;
            module_config     <= scm_pkg::RESET_CONFIG;
        end else if (bus_req_i.write) begin
            case (bus_req_i.addr)
                scm_pkg::ADDR_MODE_HIGH: begin
                    control_mode_high <= bus_req_i.wdata;
                end
                scm_pkg::ADDR_MODE_LOW: begin
                    control_mode_low <= bus_req_i.wdata;
                end
                scm_pkg::ADDR_MASK: begin
                    interrupt_mask <= bus_req_i.wdata;
                end
                scm_pkg::ADDR_AUX: begin
                    aux_control <= bus_req_i.wdata;
                end
                scm_pkg::ADDR_CONFIG: begin
                    module_config <= bus_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status capture, one bit per generate entry
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_status
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    event_status[gi] <= scm_pkg::RESET_STATUS[gi];
                end else if (sc_tick_i && status_in_i[gi] && status_capture_sel
                             && !synchronizer_mode_select) begin
                    event_status[gi] <= 1'b1;
                end else if (rd_status && event_status[gi]) begin
                    event_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Live or captured view with interrupt on top bit
    assign irq = interrupt_mode_select && aux_control[scm_pkg::AUX_INT_EN]
                 && |(status_view[6:0] & interrupt_mask[6:0]);

    always_comb begin
        status_view = status_capture_sel ? event_status : status_in_i;
        if (synchronizer_mode_select) begin
            status_view = {4'h0, sync_stage2};
        end
    end

    // ------------------------------------------------------------
    // Synchronizer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_stage1 <= 4'h0;
            sync_stage2 <= 4'h0;
        end else if (sc_tick_i) begin
            sync_stage1 <= module_routed_inputs_i;
            sync_stage2 <= sync_stage1;
        end
    end

    // ------------------------------------------------------------
    // Control register and output modes
    // ------------------------------------------------------------
    generate
        for (gi = 0; gi < 8; gi++) begin : g_control
            logic [1:0] control_bit_mode_code;
            assign control_bit_mode_code = {control_mode_high[gi], control_mode_low[gi]};

            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    routed_control[gi] <= scm_pkg::RESET_CONTROL[gi];
                end else if (wr_control && !(control_bit_mode_code == scm_pkg::CTL_PULSE
                             && pulse_active[gi])) begin
                    routed_control[gi] <= bus_req_i.wdata[gi];
                end else if (control_bit_mode_code == scm_pkg::CTL_PULSE && pulse_active[gi]
                             && sc_tick_i) begin
                    routed_control[gi] <= 1'b0;
                end
            end

            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    control_sync[gi] <= 1'b0;
                    pulse_active[gi] <= 1'b0;
                end else if (sc_tick_i) begin
                    control_sync[gi] <= routed_control[gi] && !pulse_active[gi];
                    pulse_active[gi] <= routed_control[gi] && !pulse_active[gi]
                                        && control_bit_mode_code == scm_pkg::CTL_PULSE;
                end
            end

            always_comb begin
                case (control_bit_mode_code)
                    scm_pkg::CTL_SYNC: begin
                        control_out[gi] = control_sync[gi];
                    end
                    scm_pkg::CTL_PULSE: begin
                        control_out[gi] = pulse_active[gi];
                    end
                    scm_pkg::CTL_RESERVED: begin
                        control_out[gi] = next_ctl_bit(gi);
                    end
                    default: begin
                        control_out[gi] = next_ctl_bit(gi);
                    end
                endcase
            end
        end
    endgenerate

    // Direct path value including the write in progress
    function automatic logic next_ctl_bit(input int idx);
        next_ctl_bit = wr_control ? bus_req_i.wdata[idx] : routed_control[idx];
    endfunction

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    scm_counter #(
        .WIDTH      (scm_pkg::COUNT_WIDTH)
    ) u_counter (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (sc_tick_i && counter_mode),
        .run_i      (aux_control[scm_pkg::AUX_CNT_START] && counter_enable_load_inputs_i[0]),
        .load_i     (counter_enable_load_inputs_i[1] && !synchronizer_mode_select),
        .period_i   (interrupt_mask[6:0]),
        .wr_i       (bus_req_i.write && bus_req_i.addr == scm_pkg::ADDR_COUNT),
        .wdata_i    (bus_req_i.wdata[6:0]),
        .count_o    (count),
        .terminal_o (terminal)
    );

    // ------------------------------------------------------------
    // Read data latch
    // ------------------------------------------------------------
    always_comb begin
        case (bus_req_i.addr)
            scm_pkg::ADDR_STATUS:    next_rdata = interrupt_mode_select ? {irq, status_view[6:0]}
                                                                        : status_view;
            scm_pkg::ADDR_MASK:      next_rdata = interrupt_mask;
            scm_pkg::ADDR_CONTROL:   next_rdata = routed_control;
            scm_pkg::ADDR_MODE_HIGH: next_rdata = control_mode_high;
            scm_pkg::ADDR_MODE_LOW:  next_rdata = control_mode_low;
            scm_pkg::ADDR_AUX:       next_rdata = aux_control;
            scm_pkg::ADDR_CONFIG:    next_rdata = module_config;
            default:                 next_rdata = {1'b0, count};
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_active <= 1'b0;
            bus_rdata_o <= 8'h00;
        end else begin
            read_active <= bus_req_i.read;
            if (bus_req_i.read && !read_active) begin
                bus_rdata_o <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Routed outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            module_routed_outputs_o <= 8'h00;
            module_bidir_outputs_o  <= 4'h0;
            module_bidir_oe_o       <= 4'h0;
            datapath_parallel_in_o  <= 8'h00;
        end else begin
            case (module_output_select)
                scm_pkg::OUT_PARALLEL: module_routed_outputs_o <= datapath_parallel_out_i;
                scm_pkg::OUT_COUNTER:  module_routed_outputs_o <= {terminal, count};
                default:               module_routed_outputs_o <= control_out;
            endcase
            module_bidir_outputs_o <= synchronizer_mode_select ? sync_stage2
                                                               : {irq, 3'h0};
            module_bidir_oe_o      <= synchronizer_mode_select ? 4'hF : {interrupt_mode_select, 3'h0};
            datapath_parallel_in_o <= status_in_i;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sticky_holds : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sc_tick_i && status_in_i[0] && status_capture_sel && !synchronizer_mode_select)
        |=> event_status[0])
        else $error("sticky bit not captured");

    a_read_clears : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd_status && event_status[1] && !sc_tick_i) |=> !event_status[1])
        else $error("read did not clear sticky bit");

    a_set_wins : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd_status && sc_tick_i && status_in_i[2] && status_capture_sel && !synchronizer_mode_select)
        |=> event_status[2])
        else $error("event lost under read clear");

    a_read_stable : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (read_active && bus_req_i.read) |=> $stable(bus_rdata_o))
        else $error("read data changed during access");

    a_irq_masked : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (interrupt_mask[6:0] == 7'h00) |-> !irq)
        else $error("interrupt without mask");

    a_irq_gated : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !aux_control[scm_pkg::AUX_INT_EN] |-> !irq)
        else $error("interrupt not gated by enable");

    a_direct_out : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_control && module_output_select == scm_pkg::OUT_CONTROL && !control_mode_high[3]
         && !control_mode_low[3]) |=> module_routed_outputs_o[3] == $past(bus_req_i.wdata[3]))
        else $error("direct bit not driven on write");

    a_pulse_self_clear : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sc_tick_i && g_control[4].control_bit_mode_code == scm_pkg::CTL_PULSE && pulse_active[4])
        |=> !pulse_active[4] && !routed_control[4])
        else $error("pulse did not self-clear");

    a_sync_two_stage : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sc_tick_i |=> sync_stage2 == $past(sync_stage1))
        else $error("synchronizer stage mismatch");

    c_sticky_read : cover property (@(posedge clk_i) disable iff (!reset_n_i) rd_status && event_status != 8'h00);
    c_pulse       : cover property (@(posedge clk_i) disable iff (!reset_n_i) pulse_active != 8'h00);
    c_irq         : cover property (@(posedge clk_i) disable iff (!reset_n_i) irq);
    c_counter     : cover property (@(posedge clk_i) disable iff (!reset_n_i) counter_mode && terminal);

endmodule

// >>> scm_pkg.sv
/*
 * Package for the status and control module: register offsets, field
 * positions, reset values, mode codes and the shared bus carrier.
 * Assumes a single clock domain; the status-and-control clock arrives as an
 * enable-style tick synchronous to the bus clock.
 */
package scm_pkg;

    // ------------------------------------------------------------
    // Register offsets (own choice, no bus map printed)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS    = 3'h0;
    localparam logic [2:0] ADDR_MASK      = 3'h1;
    localparam logic [2:0] ADDR_CONTROL   = 3'h2;
    localparam logic [2:0] ADDR_MODE_HIGH = 3'h3;
    localparam logic [2:0] ADDR_MODE_LOW  = 3'h4;
    localparam logic [2:0] ADDR_AUX       = 3'h5;
    localparam logic [2:0] ADDR_CONFIG    = 3'h6;
    localparam logic [2:0] ADDR_COUNT     = 3'h7;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_STATUS   = 8'h00;
    localparam logic [7:0] RESET_CONTROL  = 8'h00;
    localparam logic [7:0] RESET_MASK     = 8'h00;
    localparam logic [7:0] RESET_MODE     = 8'h00;
    localparam logic [7:0] RESET_AUX      = 8'h00;
    localparam logic [7:0] RESET_CONFIG   = 8'h00;
    localparam int         AUX_INT_EN     = 4;
    localparam int         AUX_CNT_START  = 5;
    localparam int         CFG_CAPTURE    = 0;
    localparam int         CFG_SYNCHRONIZER_MODE_SELECT    = 1;
    localparam int         CFG_INTERRUPT_MODE_SELECT     = 2;
    localparam int         CFG_OUT_SEL_LO = 3;
    localparam int         CFG_OUT_SEL_HI = 4;
    localparam int         SYNC_WIDTH     = 4;
    localparam int         COUNT_WIDTH    = 7;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] CTL_DIRECT     = 2'h0;
    localparam logic [1:0] CTL_SYNC       = 2'h1;
    localparam logic [1:0] CTL_RESERVED   = 2'h2;
    localparam logic [1:0] CTL_PULSE      = 2'h3;
    localparam logic [1:0] OUT_CONTROL    = 2'h0;
    localparam logic [1:0] OUT_PARALLEL   = 2'h1;
    localparam logic [1:0] OUT_COUNTER    = 2'h2;

    // ------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic       read;
        logic       write;
        logic [2:0] addr;
        logic [7:0] wdata;
    } scm_bus_req_t;

endpackage

// >>> scm_counter.sv
/*
 * Seven-bit down counter with reload from a period value.
 * Assumes tick_i is a one-cycle status-and-control clock enable.
 */
`timescale 1ns/1ns
module scm_counter #(
    parameter int WIDTH = scm_pkg::COUNT_WIDTH
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Control
    input  wire logic             tick_i,
    input  wire logic             run_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] period_i,
    input  wire logic             wr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Result
    output logic      [WIDTH-1:0] count_o,
    output logic                  terminal_o
);

    // ------------------------------------------------------------
    // Count and terminal flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_o <= '0;
        end else if (wr_i && !run_i) begin
            count_o <= wdata_i;
        end else if (tick_i && (load_i || (run_i && count_o == '0))) begin
            count_o <= period_i;
        end else if (tick_i && run_i) begin
            count_o <= count_o - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            terminal_o <= 1'b0;
        end else if (tick_i) begin
            terminal_o <= run_i && (count_o == '0);
        end
    end

    a_reload_at_zero : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (tick_i && run_i && !load_i && !wr_i && count_o == '0) |=> count_o == $past(period_i))
        else $error("counter did not reload at zero");

    a_count_down : assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (tick_i && run_i && !load_i && !wr_i && count_o != '0) |=> count_o == $past(count_o) - 1'b1)
        else $error("counter did not decrement");

endmodule

// >>> scm_bus_master.sv
/*
 * Bus master model for the status and control module register bus.
 * Assumes one bus clock; requests change just after its rising edge.
 */
`timescale 1ns/1ns
module scm_bus_master (
    // Bus side
    input  wire logic             clk_i,
    input  wire logic [7:0]       rdata_i,
    output scm_pkg::scm_bus_req_t req_o
);
    initial req_o = '0;
    // Write taken at one edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{read: 1'b0, write: 1'b1, addr: a, wdata: d};
        @(posedge clk_i);
        req_o.write <= 1'b0;
    endtask
    // Read held through capture, then released
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{read: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        @(posedge clk_i);
        d = rdata_i;
        req_o.read <= 1'b0;
    endtask
endmodule

// >>> test_scm_status_control.sv
/*
 * Self-checking bench for the status and control module.
 * Assumes the bus master model drives the register bus; tick every 4 clocks.
 */
`timescale 1ns/1ns
module test_scm_status_control;
    logic                  clk_i;
    logic                  reset_n_i;
    logic                  sc_tick_i = 1'b0;
    logic [1:0]            tick_cnt = 2'h0;
    logic [7:0]            status_in;
    logic [7:0]            rd_val;
    logic [7:0]            routed_out;
    logic [7:0]            bus_rdata;
    logic [3:0]            sync_in = 4'h0;
    logic [1:0]            cnt_ctl = 2'h0;
    logic [7:0]            par_out = 8'h00;
    logic [7:0]            par_in;
    logic [3:0]            bidir_out;
    logic [3:0]            bidir_oe;
    scm_pkg::scm_bus_req_t bus_req;
    int                    n_errors;
    int                    samples_checked;
    int                    n_high;

    scm_bus_master i_bus (.clk_i(clk_i), .rdata_i(bus_rdata), .req_o(bus_req));
    scm_status_control i_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .sc_tick_i(sc_tick_i),
        .bus_req_i(bus_req), .bus_rdata_o(bus_rdata), .status_in_i(status_in),
        .module_routed_inputs_i(sync_in), .counter_enable_load_inputs_i(cnt_ctl),
        .module_routed_outputs_o(routed_out), .module_bidir_outputs_o(bidir_out), .module_bidir_oe_o(bidir_oe),
        .datapath_parallel_out_i(par_out), .datapath_parallel_in_o(par_in)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tick_cnt  <= tick_cnt + 2'h1;
        sc_tick_i <= (tick_cnt == 2'h3);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic set_status(input logic [7:0] v);
        @(posedge clk_i);
        status_in <= v;
    endtask
    // Reset values
    task automatic sc_reset_values();
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, scm_pkg::RESET_STATUS);
        i_bus.rd(scm_pkg::ADDR_CONTROL, rd_val);
        chk(rd_val, scm_pkg::RESET_CONTROL);
    endtask
    // Transparent then sticky capture and clear
    task automatic sc_status();
        set_status(8'hA5);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'hA5);
        set_status(8'h00);
        i_bus.wr(scm_pkg::ADDR_CONFIG, 8'h01);
        set_status(8'h07);
        repeat (8) @(posedge clk_i);
        set_status(8'h00);
        repeat (8) @(posedge clk_i);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'h07);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'h00);
        set_status(8'h06);
        repeat (4) begin
            repeat (4) @(posedge clk_i);
            i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
            chk(rd_val, 8'h06);
        end
        set_status(8'h00);
    endtask
    // Masked interrupt on top status bit
    task automatic sc_interrupt();
        i_bus.wr(scm_pkg::ADDR_CONFIG, 8'h04);
        i_bus.wr(scm_pkg::ADDR_MASK, 8'hFF);
        i_bus.wr(scm_pkg::ADDR_AUX, 8'h10);
        set_status(8'h80);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'h00);
        set_status(8'h02);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'h82);
        i_bus.wr(scm_pkg::ADDR_AUX, 8'h00);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'h02);
        i_bus.wr(scm_pkg::ADDR_CONFIG, 8'h00);
    endtask
    // Direct and reserved codes drive written value
    task automatic sc_direct(input logic [7:0] hi, input logic [7:0] v);
        i_bus.wr(scm_pkg::ADDR_MODE_HIGH, hi);
        i_bus.wr(scm_pkg::ADDR_MODE_LOW, 8'h00);
        i_bus.wr(scm_pkg::ADDR_CONTROL, v);
        repeat (2) @(posedge clk_i);
        chk(routed_out, v);
        i_bus.rd(scm_pkg::ADDR_CONTROL, rd_val);
        chk(rd_val, v);
    endtask
    // Pulse lasts one tick period then self-clears
    task automatic sc_pulse();
        i_bus.wr(scm_pkg::ADDR_CONTROL, 8'h00);
        i_bus.wr(scm_pkg::ADDR_MODE_HIGH, 8'h11);
        i_bus.wr(scm_pkg::ADDR_MODE_LOW, 8'h11);
        i_bus.wr(scm_pkg::ADDR_CONTROL, 8'h11);
        count_high(0, 24);
        chk(8'(n_high), 8'h04);
        i_bus.rd(scm_pkg::ADDR_CONTROL, rd_val);
        chk(rd_val, 8'h00);
    endtask
    // Count routed output samples that are high
    task automatic count_high(input int b, input int n);
        n_high = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1 if (routed_out[b] === 1'b1) n_high++;
        end
    endtask
    // Sync control bits, then four-bit synchronizer
    task automatic sc_sync();
        i_bus.wr(scm_pkg::ADDR_MODE_HIGH, 8'h00);
        i_bus.wr(scm_pkg::ADDR_MODE_LOW, 8'hFF);
        i_bus.wr(scm_pkg::ADDR_CONTROL, 8'h5A);
        @(posedge clk_i);
        chk(routed_out, 8'h00);
        repeat (8) @(posedge clk_i);
        chk(routed_out, 8'h5A);
        i_bus.wr(scm_pkg::ADDR_CONFIG, 8'h02);
        sync_in <= 4'h9;
        repeat (12) @(posedge clk_i);
        chk({bidir_oe, bidir_out}, 8'hF9);
        i_bus.rd(scm_pkg::ADDR_STATUS, rd_val);
        chk(rd_val, 8'h09);
    endtask
    // Datapath parallel in and out
    task automatic sc_parallel();
        i_bus.wr(scm_pkg::ADDR_CONFIG, 8'h08);
        par_out <= 8'h6B;
        repeat (2) @(posedge clk_i);
        chk(routed_out, 8'h6B);
        chk(par_in, 8'h02);
        chk({bidir_oe, bidir_out}, 8'h00);
    endtask
    // Counter replaces control, reloads period at zero
    task automatic sc_counter();
        i_bus.wr(scm_pkg::ADDR_MASK, 8'h03);
        i_bus.wr(scm_pkg::ADDR_CONFIG, 8'h10);
        i_bus.wr(scm_pkg::ADDR_CONTROL, 8'h7F);
        i_bus.wr(scm_pkg::ADDR_COUNT, 8'h02);
        i_bus.rd(scm_pkg::ADDR_CONTROL, rd_val);
        chk(rd_val, 8'h5A);
        i_bus.rd(scm_pkg::ADDR_COUNT, rd_val);
        chk(rd_val, 8'h02);
        i_bus.wr(scm_pkg::ADDR_AUX, 8'h20);
        cnt_ctl <= 2'h1;
        repeat (8) @(posedge clk_i);
        count_high(7, 64);
        chk(8'(n_high), 8'h10);
    endtask

    initial begin
        reset_n_i = 1'b0;
        status_in = 8'h00;
        n_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        sc_reset_values();
        sc_status();
        sc_interrupt();
        sc_direct(8'h00, 8'h3C);
        sc_direct(8'hFF, 8'hC3);
        sc_pulse();
        sc_sync();
        sc_parallel();
        sc_counter();
        stop_test();
    end
    // Run limit
    initial begin
        repeat (4000) @(posedge clk_i);
        n_errors++;
        stop_test();
    end
endmodule
